// >>> include/i2c_port_pkg.sv
// Purpose: shared constants and types for the two-wire slave register port
// Assumes: 7-bit slave address, 8-bit pointer, 16-bit registers
// Notes: the fixed upper five address bits sit above the two select pins
package i2c_port_pkg;
  localparam int REG_ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int PTR_W = 8;
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h13;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] RD_DATA_RESET = 16'h0000;
  localparam logic [3:0] LINES_IDLE = 4'hf;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_RX_BYTE,
    LS_ACK_DRIVE,
    LS_TX_BYTE,
    LS_MASTER_ACK,
    LS_IGNORE
  } link_state_t;

  typedef enum logic [1:0] {
    ROLE_ADDR,
    ROLE_PTR,
    ROLE_UPPER,
    ROLE_LOWER
  } byte_role_t;
endpackage

// >>> include/line_events_if.sv
// Purpose: carries sampled bus line levels and events to the port logic
// Assumes: all signals belong to the link clock domain
// Notes: event signals are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface line_events_if;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;
  logic [1:0] addr_sel;
  modport source (output scl_rise, output scl_fall, output start_seen, output stop_seen,
                  output sda_level, output addr_sel);
  modport sink (input scl_rise, input scl_fall, input start_seen, input stop_seen,
                input sda_level, input addr_sel);
endinterface
`default_nettype wire

// >>> rtl/bus_line_sampler.sv
// Purpose: synchronise the bus pins and detect clock edges, start and stop
// Assumes: link_clk is far faster than the serial clock
// Notes: events lag the pins by about three link clock cycles
`timescale 1ns/1ns
`default_nettype none
module bus_line_sampler (
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_select_pin_low,
  input wire logic addr_select_pin_high,
  line_events_if.source ev
);
  import i2c_port_pkg::*;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;
    logic [1:0] addr_sel;
  } sampler_state_t;

  sampler_state_t q;
  sampler_state_t d;

  always_comb begin
    d = q;
    d.meta = {addr_select_pin_high, addr_select_pin_low, sda_in, scl_in};
    d.sync = q.meta;
    d.scl_prev = q.sync[0];
    d.sda_prev = q.sync[1];
    d.scl_rise = q.sync[0] & ~q.scl_prev;
    d.scl_fall = ~q.sync[0] & q.scl_prev;
    d.start_seen = q.sync[0] & q.scl_prev & q.sda_prev & ~q.sync[1];
    d.stop_seen = q.sync[0] & q.scl_prev & ~q.sda_prev & q.sync[1];
    d.sda_level = q.sync[1];
    d.addr_sel = q.sync[3:2];
    if (!link_rst_n) begin
      // Idle-high lines at reset so no false edge is seen on release
      d.sync = LINES_IDLE;
      d.scl_prev = 1'b1;
      d.sda_prev = 1'b1;
      d.scl_rise = 1'b0;
      d.scl_fall = 1'b0;
      d.start_seen = 1'b0;
      d.stop_seen = 1'b0;
      d.sda_level = 1'b1;
      d.addr_sel = 2'h0;
    end
  end

  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign ev.scl_rise = q.scl_rise;
  assign ev.scl_fall = q.scl_fall;
  assign ev.start_seen = q.start_seen;
  assign ev.stop_seen = q.stop_seen;
  assign ev.sda_level = q.sda_level;
  assign ev.addr_sel = q.addr_sel;
endmodule
`default_nettype wire

// >>> rtl/i2c_slave_register_port.sv
// Purpose: two-wire serial slave giving a bus master access to 16-bit registers
// Assumes: link_clk oversamples the bus; register file sits on core_clk
// Notes: link logic and register access cross by a toggle handshake
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_register_port (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_low,
  input wire logic addr_select_pin_high,
  output logic reg_wr_en,
  output logic [i2c_port_pkg::REG_ADDR_W-1:0] reg_wr_addr,
  output logic [i2c_port_pkg::DATA_W-1:0] reg_wr_data,
  output logic [i2c_port_pkg::REG_ADDR_W-1:0] reg_rd_addr,
  input wire logic [i2c_port_pkg::DATA_W-1:0] reg_rd_data
);
  import i2c_port_pkg::*;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    link_state_t st;
    byte_role_t role;
    logic [7:0] shift;
    logic [3:0] bits;
    logic rw;
    logic [PTR_W-1:0] ptr;
    logic [7:0] upper;
    logic sent_lower;
    logic nack;
    logic sda_oe;
    logic sda_out;
    logic req_tgl;
    logic req_write;
    logic [REG_ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    logic ack_meta;
    logic ack_sync;
    logic ack_prev;
    logic [DATA_W-1:0] fetched;
  } link_side_t;

  typedef struct packed {
    logic req_meta;
    logic req_sync;
    logic req_prev;
    logic rd_phase;
    logic ack_tgl;
    logic wr_en;
    logic [REG_ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [REG_ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
  } core_side_t;

  link_side_t link_q;
  link_side_t link_d;
  core_side_t core_q;
  core_side_t core_d;

  line_events_if ev ();

  bus_line_sampler sampler (
    .link_clk(link_clk),
    .link_rst_n(link_q.rst_sync),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .addr_select_pin_low(addr_select_pin_low),
    .addr_select_pin_high(addr_select_pin_high),
    .ev(ev)
  );

  // ---------------- link clock domain ----------------
  always_comb begin
    link_d = link_q;
    link_d.rst_meta = rst_n;
    link_d.rst_sync = link_q.rst_meta;
    link_d.ack_meta = core_q.ack_tgl;
    link_d.ack_sync = link_q.ack_meta;
    link_d.ack_prev = link_q.ack_sync;
    // Core data changed with its toggle and has settled by the time the synchronised toggle is seen, so a copy is safe here
    if (link_q.ack_sync != link_q.ack_prev) begin
      link_d.fetched = core_q.rd_data;
    end

    if (ev.start_seen) begin
      link_d.st = LS_RX_BYTE;
      link_d.role = ROLE_ADDR;
      link_d.bits = 4'h0;
      link_d.sda_oe = 1'b0;
    end else if (ev.stop_seen) begin
      link_d.st = LS_IDLE;
      link_d.sda_oe = 1'b0;
    end else begin
      case (link_q.st)
        LS_RX_BYTE: begin
          if (ev.scl_rise && link_q.bits != BITS_PER_BYTE) begin
            link_d.shift = {link_q.shift[6:0], ev.sda_level};
            link_d.bits = link_q.bits + 4'h1;
          end
          if (ev.scl_fall && link_q.bits == BITS_PER_BYTE) begin
            link_d.bits = 4'h0;
            link_d.st = LS_ACK_DRIVE;
            link_d.sda_oe = 1'b1;
            case (link_q.role)
              ROLE_ADDR: begin
                if (link_q.shift[7:1] == {DEV_ADDR_FIXED, ev.addr_sel}) begin
                  link_d.rw = link_q.shift[0];
                  if (link_q.shift[0]) begin
                    link_d.req_tgl = ~link_q.req_tgl;
                    link_d.req_write = 1'b0;
                    link_d.req_addr = link_q.ptr[REG_ADDR_W-1:0];
                  end
                end else begin
                  link_d.st = LS_IGNORE;
                  link_d.sda_oe = 1'b0;
                end
              end
              ROLE_PTR: link_d.ptr = link_q.shift;
              ROLE_UPPER: link_d.upper = link_q.shift;
              default: begin
              end
            endcase
          end
        end

        LS_ACK_DRIVE: begin
          // held low until the ninth clock falls
          if (ev.scl_fall) begin
            link_d.sda_oe = 1'b0;
            link_d.bits = 4'h0;
            link_d.st = LS_RX_BYTE;
            case (link_q.role)
              ROLE_ADDR: begin
                if (link_q.rw) begin
                  link_d.st = LS_TX_BYTE;
                  link_d.shift = link_q.fetched[15:8];
                  link_d.sda_oe = ~link_q.fetched[15];
                  link_d.sent_lower = 1'b0;
                end else begin
                  link_d.role = ROLE_PTR;
                end
              end
              ROLE_PTR: link_d.role = ROLE_UPPER;
              ROLE_UPPER: link_d.role = ROLE_LOWER;
              default: begin
                // write only once both bytes acknowledged
                link_d.req_tgl = ~link_q.req_tgl;
                link_d.req_write = 1'b1;
                link_d.req_addr = link_q.ptr[REG_ADDR_W-1:0];
                link_d.req_data = {link_q.upper, link_q.shift};
                link_d.ptr = link_q.ptr + 8'h01;
                // next group starts with upper byte
                link_d.role = ROLE_UPPER;
              end
            endcase
          end
        end

        LS_TX_BYTE: begin
          // Changing data only after a seen fall keeps it steady while high
          // change only with clock low
          if (ev.scl_fall) begin
            if (link_q.bits + 4'h1 == BITS_PER_BYTE) begin
              // free the line for the master's acknowledge
              link_d.sda_oe = 1'b0;
              link_d.bits = 4'h0;
              link_d.nack = 1'b0;
              link_d.st = LS_MASTER_ACK;
            end else begin
              link_d.shift = {link_q.shift[6:0], 1'b0};
              link_d.sda_oe = ~link_q.shift[6];
              link_d.bits = link_q.bits + 4'h1;
            end
          end
        end

        LS_MASTER_ACK: begin
          if (ev.scl_rise) begin
            link_d.nack = ev.sda_level;
          end
          if (ev.scl_fall) begin
            link_d.st = LS_TX_BYTE;
            if (link_q.nack) begin
              // leave data high for the stop
              link_d.st = LS_IGNORE;
              link_d.sda_oe = 1'b0;
            end else if (!link_q.sent_lower) begin
              link_d.shift = link_q.fetched[7:0];
              link_d.sda_oe = ~link_q.fetched[7];
              link_d.sent_lower = 1'b1;
              // advance and prefetch the next group
              link_d.ptr = link_q.ptr + 8'h01;
              link_d.req_tgl = ~link_q.req_tgl;
              link_d.req_write = 1'b0;
              link_d.req_addr = link_d.ptr[REG_ADDR_W-1:0];
            end else begin
              link_d.shift = link_q.fetched[15:8];
              link_d.sda_oe = ~link_q.fetched[15];
              link_d.sent_lower = 1'b0;
            end
          end
        end

        LS_IDLE, LS_IGNORE: begin
        end

        default: link_d.st = LS_IDLE;
      endcase
    end

    if (!link_q.rst_sync) begin
      link_d = '0;
      link_d.rst_meta = rst_n;
      link_d.rst_sync = link_q.rst_meta;
      link_d.st = LS_IDLE;
      link_d.role = ROLE_ADDR;
      link_d.ptr = PTR_RESET;
      link_d.fetched = RD_DATA_RESET;
    end
  end

  always_ff @(posedge link_clk) begin
    link_q <= link_d;
  end

  // ---------------- core clock domain ----------------
  always_comb begin
    core_d = core_q;
    core_d.req_meta = link_q.req_tgl;
    core_d.req_sync = core_q.req_meta;
    core_d.req_prev = core_q.req_sync;
    core_d.wr_en = 1'b0;
    core_d.rd_phase = 1'b0;
    // Request fields are held by the link side until its next toggle
    if (core_q.req_sync != core_q.req_prev) begin
      if (link_q.req_write) begin
        core_d.wr_en = 1'b1;
        core_d.wr_addr = link_q.req_addr;
        core_d.wr_data = link_q.req_data;
      end else begin
        core_d.rd_addr = link_q.req_addr;
        core_d.rd_phase = 1'b1;
      end
    end
    // Read data is taken one cycle after the address is presented
    if (core_q.rd_phase) begin
      core_d.rd_data = reg_rd_data;
      core_d.ack_tgl = ~core_q.ack_tgl;
    end
    if (!rst_n) begin
      core_d = '0;
      core_d.rd_data = RD_DATA_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    core_q <= core_d;
  end

  // no serial clock output exists; data is pull-low only
  assign sda_out = link_q.sda_out;
  assign sda_oe = link_q.sda_oe;
  assign reg_wr_en = core_q.wr_en;
  assign reg_wr_addr = core_q.wr_addr;
  assign reg_wr_data = core_q.wr_data;
  assign reg_rd_addr = core_q.rd_addr;
endmodule
`default_nettype wire

// >>> test/bus_master_model.sv
// Purpose: behavioural two-wire bus master driving the port pins
// Assumes: the data wire is pulled up and fed back on sda_wire
// Notes: half period 1520 ns keeps the serial clock below 400 kHz
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  localparam int HALF = 1520;
  localparam int HOLD = 120;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start_cond();
    #HOLD sda_pull = 1'b0;
    #(HALF-HOLD) scl = 1'b1;
    #HALF sda_pull = 1'b1;
    #HALF scl = 1'b0;
  endtask
  task automatic stop_cond();
    #HOLD sda_pull = 1'b1;
    #(HALF-HOLD) scl = 1'b1;
    #HALF sda_pull = 1'b0;
    #HALF;
  endtask
  // data only moves with clock low
  task automatic clock_bit(input logic b, output logic seen);
    #HOLD sda_pull = ~b;
    #(HALF-HOLD) scl = 1'b1;
    #(HALF/2) seen = sda_wire;
    #(HALF/2) scl = 1'b0;
  endtask
  // msb first, line freed for ack
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, nack);
  endtask
  task automatic recv_byte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, b[i]);
    end
    clock_bit(last, s);
  endtask
endmodule
`default_nettype wire

// >>> test/i2c_slave_register_port_asserts.sv
// Purpose: pin timing checks for the register port
// Assumes: link_clk oversamples the serial clock
// Notes: bound to every instance of the port
`timescale 1ns/1ns
`default_nettype none
module port_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic reg_wr_en,
  input wire logic [i2c_port_pkg::REG_ADDR_W-1:0] reg_wr_addr,
  input wire logic [i2c_port_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic [i2c_port_pkg::REG_ADDR_W-1:0] reg_rd_addr
);
  import i2c_port_pkg::*;
  // Link side leaves reset a few link cycles after rst_n; its outputs are unknown until then
  logic [2:0] link_settle_q;
  logic link_unsettled;
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      link_settle_q <= 3'h0;
    end else if (link_settle_q != 3'h6) begin
      link_settle_q <= link_settle_q + 3'h1;
    end
  end
  assign link_unsettled = !rst_n || (link_settle_q != 3'h6);
  pin_low_only_a: assert property (@(posedge link_clk) disable iff (link_unsettled) sda_out == 1'b0)
    else $error("data pin driven high");
  pull_starts_low_a: assert property (@(posedge link_clk) disable iff (link_unsettled)
    $rose(sda_oe) |-> !scl_in)
    else $error("pull began with clock high");
  release_clk_low_a: assert property (@(posedge link_clk) disable iff (link_unsettled)
    $fell(sda_oe) |-> !scl_in)
    else $error("release with clock high");
  ack_hold_high_a: assert property (@(posedge link_clk) disable iff (link_unsettled)
    $rose(scl_in) && sda_oe |-> sda_oe [*4])
    else $error("pull dropped in clock high");
  start_free_a: assert property (@(posedge link_clk) disable iff (link_unsettled)
    scl_in && $fell(sda_in) |-> !sda_oe)
    else $error("pull during start");
  wr_pulse_once_a: assert property (@(posedge core_clk) disable iff (!rst_n) reg_wr_en |=> !reg_wr_en [*8])
    else $error("write strobe too long");
  wr_with_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(reg_wr_addr) || $changed(reg_wr_data) |-> reg_wr_en)
    else $error("write fields moved alone");
  rd_addr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(reg_rd_addr) |=> $stable(reg_rd_addr))
    else $error("read address too short");
  cover property (@(posedge core_clk) reg_wr_en);
  cover property (@(posedge link_clk) $rose(sda_oe));
  cover property (@(posedge core_clk) $changed(reg_rd_addr));
endmodule
bind i2c_slave_register_port port_checker chk (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .reg_wr_en(reg_wr_en),
  .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr));
`default_nettype wire

// >>> test/tb_i2c_slave_register_port.sv
// Purpose: self-checking bench for the two-wire register port
// Assumes: master model on the pins, register array on the core side
// Notes: link clock 125 ns, unrelated to core_clk
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_slave_register_port;
  import i2c_port_pkg::*;
  logic core_clk, link_clk, rst_n, scl, m_pull, sda_out, sda_oe, reg_wr_en;
  logic [1:0] sel;
  logic [REG_ADDR_W-1:0] reg_wr_addr, reg_rd_addr;
  logic [DATA_W-1:0] reg_wr_data, reg_rd_data;
  logic [DATA_W-1:0] regs [128];
  wire logic sda_wire;
  int fail_count, check_count, wr_count;
  // Pull-up wins unless someone pulls low
  assign sda_wire = ~(m_pull | (sda_oe & ~sda_out));
  assign reg_rd_data = regs[reg_rd_addr];
  i2c_slave_register_port dut (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_low(sel[0]),
    .addr_select_pin_high(sel[1]), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data));
  bus_master_model master (.sda_wire(sda_wire), .scl(scl), .sda_pull(m_pull));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever begin
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
  end
  always @(posedge core_clk) begin
    if (!rst_n) begin
      foreach (regs[i]) regs[i] <= 16'h0000;
      regs[32] <= 16'hbeef;
      regs[33] <= 16'h0f1e;
      wr_count <= 0;
    end else if (reg_wr_en === 1'b1) begin
      regs[reg_wr_addr] <= reg_wr_data;
      wr_count <= wr_count + 1;
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] dev(input logic [1:0] s, input logic rd);
    return {DEV_ADDR_FIXED, s, rd};
  endfunction
  task automatic put(input logic [7:0] b, input logic exp_nack, input string what);
    logic n;
    master.send_byte(b, n);
    check(what, {15'h0, exp_nack}, {15'h0, n});
  endtask
  task automatic t_write();
    int base;
    base = wr_count;
    master.start_cond();
    put(dev(2'b10, 1'b0), 1'b0, "wr addr");
    put(8'h05, 1'b0, "pointer");
    put(8'h12, 1'b0, "upper 1");
    put(8'h34, 1'b0, "lower 1");
    put(8'hab, 1'b0, "upper 2");
    put(8'hcd, 1'b0, "lower 2");
    master.stop_cond();
    repeat (20) @(posedge core_clk);
    check("reg 05", 16'h1234, regs[5]);
    check("reg 06", 16'habcd, regs[6]);
    check("writes", 16'h2, 16'(wr_count - base));
  endtask
  task automatic t_partial();
    int base;
    base = wr_count;
    master.start_cond();
    put(dev(2'b10, 1'b0), 1'b0, "p addr");
    put(8'h10, 1'b0, "p pointer");
    put(8'h55, 1'b0, "p upper");
    master.stop_cond();
    repeat (20) @(posedge core_clk);
    check("reg 10", 16'h0000, regs[16]);
    check("p writes", 16'h0, 16'(wr_count - base));
  endtask
  task automatic t_read();
    logic [15:0] b;
    master.start_cond();
    put(dev(2'b10, 1'b0), 1'b0, "r addr w");
    put(8'h20, 1'b0, "r pointer");
    master.start_cond();
    put(dev(2'b10, 1'b1), 1'b0, "r addr r");
    master.recv_byte(b[15:8], 1'b0);
    master.recv_byte(b[7:0], 1'b0);
    check("read 20", 16'hbeef, b);
    master.recv_byte(b[15:8], 1'b0);
    master.recv_byte(b[7:0], 1'b1);
    check("read 21", 16'h0f1e, b);
    // Next register is zero, so a late driver would show as a pull
    #1000;
    check("released", 16'h0, {15'h0, sda_oe});
    master.stop_cond();
  endtask
  task automatic t_select();
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      #1 sel = 2'(k);
      repeat (20) @(posedge core_clk);
      master.start_cond();
      put(dev(2'(k), 1'b0), 1'b0, "sel ack");
      master.start_cond();
      put(dev(2'(k) ^ 2'b01, 1'b0), 1'b1, "other nack");
      put(8'h00, 1'b1, "ignored");
      master.stop_cond();
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    sel = 2'b10;
    fail_count = 0;
    check_count = 0;
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge core_clk);
    t_write();
    t_partial();
    t_read();
    t_select();
    tally_and_finish();
  end
  initial begin
    #3000000;
    fail_count++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
`default_nettype wire
